// >>> rtl/lsbs_pkg.sv
// Purpose: shared constants for the latched system bus requesting agent
// Assumes: one bus clock, every pin registered at the pad
// Notes:   pin vectors are carried active low, exactly as they stand on the wires
package lsbs_pkg;
	// ----------------------------------------------------------------
	// pin geometry
	// ----------------------------------------------------------------
	localparam int LSBS_REQ_LSB = 3; // request pins run 35 down to 3
	localparam int LSBS_REQ_W = 33;
	localparam int LSBS_DID_W = 8;
	localparam int LSBS_DID_PIN = 16; // deferred id sits on pins 23:16 in clock b
	localparam int LSBS_BE_W = 8;
	localparam int LSBS_BE_PIN = 8; // byte enables on pins 15:8 in clock b
	localparam int LSBS_LEN_W = 2;
	localparam int LSBS_LEN_PIN = 4; // length on pins 5:4 in clock b
	// ----------------------------------------------------------------
	// wired-or group, index of each signal in the settle vector
	// ----------------------------------------------------------------
	localparam int LSBS_WO_N = 6;
	localparam int LSBS_WO_INIT = 0;
	localparam int LSBS_WO_SHARED = 1;
	localparam int LSBS_WO_MOD = 2;
	localparam int LSBS_WO_BNR = 3;
	localparam int LSBS_WO_PERR = 4;
	localparam int LSBS_WO_FAULT = 5;
	// ----------------------------------------------------------------
	// timing, in bus clocks
	// ----------------------------------------------------------------
	localparam int LSBS_REQ_CLKS = 2; // request phase length
	localparam int LSBS_ERR_PHASE_CLKS = 3; // error phase after request start
	localparam int LSBS_SYNC_STAGES = 2; // input flops before any logic
	localparam int LSBS_SETTLE_STAGES = 1; // settle filter flop behind the input flops
	// clock at which an error-phase answer driven by a peer has reached the settled level
	localparam int LSBS_ERR_SEEN_CLKS =
		LSBS_ERR_PHASE_CLKS + LSBS_SYNC_STAGES + LSBS_SETTLE_STAGES;
	localparam int LSBS_CNT_W = 4;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LSBS_IDLE,
		LSBS_ARB,
		LSBS_REQ_A,
		LSBS_REQ_B,
		LSBS_ERR_WAIT,
		LSBS_DONE
	} lsbs_state_t;
endpackage : lsbs_pkg

// >>> rtl/lsbs_host.sv
// Purpose: requesting bus agent that arbitrates and runs the request and error phases
// Assumes: peers keep the same latched protocol; grant comes from an external arbiter
// Notes:   snoop, response and data phases are left to later logic; this agent
//          retires a transaction once its error phase has been judged
// Operation
// - all pins change and are captured only on the rising bus clock edge
// - every pin goes straight into or out of a flip-flop, no gates between
// - a captured input affects driven outputs no earlier than the next edge
// - asserted in T1, seen in T2, decided in T2, reply driven in T3; here grant passes two input flops, is decided in T3 and strobe is driven in T4
// - every bus value is treated as seen one clock after it was driven; this agent acts on grant two clocks and on wired-or three clocks after
// - wired-or signals count as inactive only after two clocks deasserted
// - names ending in _n are active low, others active high
// - internal flags hold 1 for asserted regardless of pin voltage
// - clock a carries address, clock b carries deferred id on pins 23:16
// - a transaction starts with arbitration, then strobe plus address
// - up to six phases in order: arbitration, request, error, snoop, response, data
// - an atomic operation may span several transactions or several transfers
// - the request phase lasts exactly two clocks, strobe and address first
// - the error phase comes three clocks after the request phase starts
`timescale 1ns/1ps
module lsbs_host (
	input wire logic clk_sys,
	input wire logic reset_n,
	// user command side
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [lsbs_pkg::LSBS_REQ_W-1:0] cmd_addr,
	input wire logic [lsbs_pkg::LSBS_DID_W-1:0] cmd_did,
	input wire logic [lsbs_pkg::LSBS_BE_W-1:0] cmd_be,
	input wire logic [lsbs_pkg::LSBS_LEN_W-1:0] cmd_len,
	input wire logic cmd_keep_bus,
	output logic done,
	output logic done_fault,
	output logic busy,
	output logic bus_init_seen,
	// bus pins
	output logic bus_request_n,
	input wire logic bus_grant_n,
	output logic address_strobe_n_out,
	output logic address_strobe_n_oe,
	output logic [lsbs_pkg::LSBS_REQ_W-1:0] req_pins_n_out,
	output logic req_pins_n_oe,
	input wire logic bus_init_n,
	input wire logic snoop_shared_n,
	input wire logic snoop_modified_n,
	input wire logic block_next_request_n,
	input wire logic request_parity_fault_n,
	input wire logic bus_fault_n
);
	import lsbs_pkg::*;

	// ----------------------------------------------------------------
	// input capture
	// ----------------------------------------------------------------
	logic [LSBS_WO_N-1:0] wo_pin;
	logic [LSBS_WO_N-1:0] wo_s1_q, wo_s1_d;
	logic [LSBS_WO_N-1:0] wo_s2_q, wo_s2_d;
	logic [LSBS_WO_N-1:0] wo_hi_q, wo_hi_d; // saw electrical high last clock
	logic [LSBS_WO_N-1:0] wo_act_q, wo_act_d; // settled logical level, 1 = asserted
	logic gnt_s1_q, gnt_s1_d;
	logic gnt_s2_q, gnt_s2_d;

	assign wo_pin[LSBS_WO_INIT] = bus_init_n;
	assign wo_pin[LSBS_WO_SHARED] = snoop_shared_n;
	assign wo_pin[LSBS_WO_MOD] = snoop_modified_n;
	assign wo_pin[LSBS_WO_BNR] = block_next_request_n;
	assign wo_pin[LSBS_WO_PERR] = request_parity_fault_n;
	assign wo_pin[LSBS_WO_FAULT] = bus_fault_n;

	// pins land in a flop with no gate before it; the second flop guards metastability
	always_comb begin
		wo_s1_d = wo_pin;
		wo_s2_d = wo_s1_q;
		gnt_s1_d = bus_grant_n;
		gnt_s2_d = gnt_s1_q;
	end

	// settle filter per wired-or signal: a low sample asserts at once, but the
	// release glitch means high is trusted only on the second consecutive clock
	genvar gi;
	generate
		for (gi = 0; gi < LSBS_WO_N; gi++) begin : g_settle
			always_comb begin
				wo_hi_d[gi] = wo_s2_q[gi];
				if (!wo_s2_q[gi]) begin
					wo_act_d[gi] = 1'b1;
				end else if (wo_hi_q[gi]) begin
					wo_act_d[gi] = 1'b0;
				end else begin
					wo_act_d[gi] = wo_act_q[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wo_s1_q <= '1;
			wo_s2_q <= '1;
			wo_hi_q <= '1;
			wo_act_q <= '0;
			gnt_s1_q <= 1'b1;
			gnt_s2_q <= 1'b1;
		end else begin
			wo_s1_q <= wo_s1_d;
			wo_s2_q <= wo_s2_d;
			wo_hi_q <= wo_hi_d;
			wo_act_q <= wo_act_d;
			gnt_s1_q <= gnt_s1_d;
			gnt_s2_q <= gnt_s2_d;
		end
	end

	// ----------------------------------------------------------------
	// transaction sequencer
	// ----------------------------------------------------------------
	lsbs_state_t state_q, state_d;
	logic [LSBS_CNT_W-1:0] cnt_q, cnt_d; // clocks since strobe was on the wires
	logic [LSBS_REQ_W-1:0] addr_q, addr_d;
	logic [LSBS_DID_W-1:0] did_q, did_d;
	logic [LSBS_BE_W-1:0] be_q, be_d;
	logic [LSBS_LEN_W-1:0] len_q, len_d;
	logic keep_q, keep_d;
	logic owner_q, owner_d; // bus still ours from the previous transaction
	logic fault_q, fault_d;
	logic done_q, done_d;
	logic done_fault_q, done_fault_d;
	logic breq_q, breq_d;
	logic ads_q, ads_d;
	logic [LSBS_REQ_W-1:0] pins_q, pins_d;
	logic drive_q, drive_d;
	logic granted;
	logic init_act;

	assign granted = !gnt_s2_q;
	assign init_act = wo_act_q[LSBS_WO_INIT];

	// new work only when nobody blocks the next request and the bus is not in init
	assign cmd_ready = (state_q == LSBS_IDLE) && !wo_act_q[LSBS_WO_BNR] && !init_act;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		did_d = did_q;
		be_d = be_q;
		len_d = len_q;
		keep_d = keep_q;
		owner_d = owner_q;
		fault_d = fault_q;
		done_d = 1'b0;
		done_fault_d = 1'b0;
		breq_d = 1'b0;
		ads_d = 1'b0;
		pins_d = '0;
		drive_d = 1'b0;
		unique case (state_q)
			LSBS_IDLE: begin
				if (!granted) begin
					owner_d = 1'b0;
				end
				// an owner keeps requesting, else the grant lapses before the next part
				breq_d = owner_q && granted;
				if (cmd_valid && cmd_ready) begin
					addr_d = cmd_addr;
					did_d = cmd_did;
					be_d = cmd_be;
					len_d = cmd_len;
					keep_d = cmd_keep_bus;
					fault_d = 1'b0;
					if (owner_q && granted) begin
						// already owner: arbitration is implicit
						state_d = LSBS_REQ_A;
						ads_d = 1'b1;
						pins_d = cmd_addr;
						drive_d = 1'b1;
					end else begin
						state_d = LSBS_ARB;
						breq_d = 1'b1;
					end
				end
			end
			LSBS_ARB: begin
				breq_d = 1'b1;
				// grant was seen through the capture flops, so it acts one edge later
				if (granted) begin
					state_d = LSBS_REQ_A;
					ads_d = 1'b1;
					pins_d = addr_q;
					drive_d = 1'b1;
				end
			end
			LSBS_REQ_A: begin
				// clock b: deferred id, byte enables and length share the pins
				state_d = LSBS_REQ_B;
				breq_d = 1'b1;
				pins_d[LSBS_DID_PIN-LSBS_REQ_LSB +: LSBS_DID_W] = did_q;
				pins_d[LSBS_BE_PIN-LSBS_REQ_LSB +: LSBS_BE_W] = be_q;
				pins_d[LSBS_LEN_PIN-LSBS_REQ_LSB +: LSBS_LEN_W] = len_q;
				drive_d = 1'b1;
				cnt_d = LSBS_CNT_W'(1);
			end
			LSBS_REQ_B: begin
				state_d = LSBS_ERR_WAIT;
				breq_d = keep_q;
				cnt_d = LSBS_CNT_W'(LSBS_REQ_CLKS);
			end
			LSBS_ERR_WAIT: begin
				breq_d = keep_q;
				cnt_d = cnt_q + LSBS_CNT_W'(1);
				// error phase driven at clock 3, reaches the settled level after the
				// capture and settle flops; that is the only clock the fault is judged
				if (cnt_q == LSBS_CNT_W'(LSBS_ERR_SEEN_CLKS)) begin
					fault_d = wo_act_q[LSBS_WO_PERR];
					state_d = LSBS_DONE;
				end
			end
			LSBS_DONE: begin
				breq_d = keep_q;
				done_d = 1'b1;
				done_fault_d = fault_q;
				owner_d = keep_q && granted;
				state_d = LSBS_IDLE;
			end
			default: begin
				state_d = LSBS_IDLE;
			end
		endcase
		// bus init drops everything in flight and releases the bus
		if (init_act) begin
			state_d = LSBS_IDLE;
			owner_d = 1'b0;
			breq_d = 1'b0;
			ads_d = 1'b0;
			drive_d = 1'b0;
			pins_d = '0;
			done_d = 1'b0;
			done_fault_d = 1'b0;
		end
	end

	// bus pins leave straight from flops, inactive from reset onward
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= LSBS_IDLE;
			cnt_q <= '0;
			addr_q <= '0;
			did_q <= '0;
			be_q <= '0;
			len_q <= '0;
			keep_q <= 1'b0;
			owner_q <= 1'b0;
			fault_q <= 1'b0;
			done_q <= 1'b0;
			done_fault_q <= 1'b0;
			breq_q <= 1'b0;
			ads_q <= 1'b0;
			pins_q <= '0;
			drive_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			did_q <= did_d;
			be_q <= be_d;
			len_q <= len_d;
			keep_q <= keep_d;
			owner_q <= owner_d;
			fault_q <= fault_d;
			done_q <= done_d;
			done_fault_q <= done_fault_d;
			breq_q <= breq_d;
			ads_q <= ads_d;
			pins_q <= pins_d;
			drive_q <= drive_d;
		end
	end

	// ----------------------------------------------------------------
	// pin and status drive
	// ----------------------------------------------------------------
	// logical 1 becomes electrical low; inversion is wiring only, no gate in timing
	assign bus_request_n = !breq_q;
	assign address_strobe_n_out = !ads_q;
	assign address_strobe_n_oe = drive_q;
	assign req_pins_n_out = ~pins_q;
	assign req_pins_n_oe = drive_q;
	assign done = done_q;
	assign done_fault = done_fault_q;
	assign busy = (state_q != LSBS_IDLE);
	assign bus_init_seen = init_act;
endmodule : lsbs_host

// >>> dv/lsbs_host_asserts.sv
// Purpose: concurrent checks on the requesting agent pins
// Assumes: one bus clock, asynchronous active-low reset
// Notes:   sees top-level ports only, attached by bind
`timescale 1ns/1ps
module lsbs_host_asserts (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic done_fault,
	input wire logic busy,
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic address_strobe_n_out,
	input wire logic address_strobe_n_oe,
	input wire logic [lsbs_pkg::LSBS_REQ_W-1:0] req_pins_n_out,
	input wire logic req_pins_n_oe,
	input wire logic bus_init_n,
	input wire logic block_next_request_n,
	input wire logic request_parity_fault_n
);
	import lsbs_pkg::*;
	// ----------------------------------------------------------------
	// properties, all on the bus clock
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// reset check must stay live while reset is low; the first edge only loads the flops
	property p_reset_quiet;
		disable iff (1'b0) (!reset_n ##1 !reset_n) |-> bus_request_n && address_strobe_n_out
			&& !address_strobe_n_oe && !req_pins_n_oe && !done;
	endproperty
	// grant seen before the strobe, and still ours with our request up at the strobe
	property p_strobe_grant;
		$fell(address_strobe_n_out) |-> !$past(bus_grant_n, 3) && !bus_grant_n
			&& !bus_request_n;
	endproperty
	property p_phase_shape;
		$fell(address_strobe_n_out) |-> address_strobe_n_oe && req_pins_n_oe
			##1 address_strobe_n_out && req_pins_n_oe ##1 !req_pins_n_oe && !address_strobe_n_oe;
	endproperty
	// unused pins in clock b must stay deasserted, i.e. electrically high
	property p_pins_b;
		$fell(address_strobe_n_out) |=> (&req_pins_n_out[32:21]) && (&req_pins_n_out[4:3])
			&& req_pins_n_out[0];
	endproperty
	property p_err_phase;
		$fell(address_strobe_n_out) |-> ##8 done && (done_fault == !$past(request_parity_fault_n, 5));
	endproperty
	property p_done_pulse;
		done |=> !done;
	endproperty
	property p_bnr_block;
		!block_next_request_n [*5] |-> !cmd_ready;
	endproperty
	// wired-or glitch: a fresh high is not trusted for two clocks
	property p_bnr_settle;
		!block_next_request_n [*5] ##1 block_next_request_n |-> !cmd_ready [*3];
	endproperty
	property p_init_abort;
		!bus_init_n [*5] |-> !address_strobe_n_oe && !done && !busy && !cmd_ready;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
	a_strobe_grant: assert property (p_strobe_grant) else $error("strobe without grant");
	a_phase_shape: assert property (p_phase_shape) else $error("request phase shape");
	a_pins_b: assert property (p_pins_b) else $error("stray pins in clock b");
	a_err_phase: assert property (p_err_phase) else $error("error phase verdict");
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
	a_bnr_block: assert property (p_bnr_block) else $error("ready while blocked");
	a_bnr_settle: assert property (p_bnr_settle) else $error("block released early");
	a_init_abort: assert property (p_init_abort) else $error("bus init not obeyed");
	c_done: cover property (done && !done_fault);
	c_fault: cover property (done && done_fault);
	c_abort: cover property ($fell(bus_init_n) && busy);
endmodule : lsbs_host_asserts

bind lsbs_host lsbs_host_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.cmd_ready(cmd_ready), .done(done), .done_fault(done_fault), .busy(busy),
	.bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n),
	.address_strobe_n_out(address_strobe_n_out), .address_strobe_n_oe(address_strobe_n_oe),
	.req_pins_n_out(req_pins_n_out), .req_pins_n_oe(req_pins_n_oe), .bus_init_n(bus_init_n),
	.block_next_request_n(block_next_request_n),
	.request_parity_fault_n(request_parity_fault_n));

// >>> dv/lsbs_peer.sv
// Purpose: peer agents: arbiter grant and error-phase answer
// Assumes: wired-or lines have pull-ups, so released lines read high
// Notes:   grant delay and fault answer are set by the bench
`timescale 1ns/1ps
module lsbs_peer (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic bus_request_n,
	input wire logic address_strobe_n_out,
	input wire logic address_strobe_n_oe,
	input wire logic [3:0] gdly,
	input wire logic fen,
	input wire logic blk,
	input wire logic ini,
	output logic bus_grant_n,
	output logic request_parity_fault_n,
	output wire logic block_next_request_n,
	output wire logic bus_init_n,
	output wire logic snoop_shared_n,
	output wire logic snoop_modified_n,
	output wire logic bus_fault_n
);
	logic [3:0] wait_q;
	logic [1:0] ecnt_q;
	// ----------------------------------------------------------------
	// latched peer logic, grant and fault answer straight from flops
	// ----------------------------------------------------------------
	// a seen strobe starts the count; fault is driven three clocks after it
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bus_grant_n <= 1'b1;
			request_parity_fault_n <= 1'b1;
			wait_q <= 4'h0;
			ecnt_q <= 2'h0;
		end else begin
			if (!bus_request_n) begin
				if (wait_q >= gdly) bus_grant_n <= 1'b0;
				else wait_q <= wait_q + 4'h1;
			end else begin
				bus_grant_n <= 1'b1;
				wait_q <= 4'h0;
			end
			if (!address_strobe_n_out && address_strobe_n_oe) ecnt_q <= 2'h1;
			else if (ecnt_q != 2'h0) ecnt_q <= ecnt_q + 2'h1;
			request_parity_fault_n <= !(fen && ecnt_q == 2'h2);
		end
	end
	// idle wired-or lines float to the pull-up level
	assign block_next_request_n = !blk;
	assign bus_init_n = !ini;
	assign snoop_shared_n = 1'b1;
	assign snoop_modified_n = 1'b1;
	assign bus_fault_n = 1'b1;
endmodule : lsbs_peer

// >>> dv/lsbs_host_tb.sv
// Purpose: directed bench for the requesting bus agent
// Assumes: inputs change on the falling edge
// Notes:   each task judges its own scenario before returning
`timescale 1ns/1ps
module lsbs_host_tb;
	import lsbs_pkg::*;
	logic clk_sys = 0, reset_n = 0, cmd_valid = 0, cmd_keep_bus = 0, fen = 0, blk = 0, ini = 0;
	logic [32:0] cmd_addr = '0;
	logic [7:0] cmd_did = '0, cmd_be = '0;
	logic [1:0] cmd_len = '0;
	logic [3:0] gdly = '0;
	int err_count = 0, cmp_count = 0, cyc = 0;
	wire cmd_ready, done, done_fault, busy, bus_init_seen, bus_request_n, bus_grant_n;
	wire address_strobe_n_out, address_strobe_n_oe, req_pins_n_oe, bus_init_n;
	wire snoop_shared_n, snoop_modified_n, block_next_request_n, request_parity_fault_n;
	wire bus_fault_n;
	wire [32:0] req_pins_n_out;
	lsbs_host uut (.*);
	lsbs_peer u_peer (.*);
	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	always #25 clk_sys = ~clk_sys;
	// a hang would otherwise hide every later failure
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			end_of_test();
		end
	end
	task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task t_reset;
		@(negedge clk_sys) reset_n = 0;
		repeat (7) @(negedge clk_sys);
		chk("rst_req", 1, bus_request_n);
		chk("rst_oe", 0, {address_strobe_n_oe, req_pins_n_oe, done});
		// pins the device latches as configuration at release must read inactive
		chk("cfg_pins", '1, req_pins_n_out);
		reset_n = 1;
		$display("reset test end");
	endtask : t_reset
	// offer a command and wait until the next rising edge will take it
	task offer(input logic [32:0] a, input logic k);
		int n;
		@(negedge clk_sys);
		cmd_valid = 1;
		cmd_addr = a;
		cmd_keep_bus = k;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : offer
	task run_cmd(input logic [32:0] a, input logic [7:0] d, input logic [7:0] b,
			input logic [1:0] l, input logic f, input logic k);
		logic [32:0] pa, pb, eb;
		int n, sa;
		logic dn;
		eb = '1;
		eb[20:13] = ~d;
		eb[12:5] = ~b;
		eb[2:1] = ~l;
		pa = 'x;
		pb = 'x;
		sa = -9;
		dn = 0;
		fen = f;
		cmd_did = d;
		cmd_be = b;
		cmd_len = l;
		offer(a, k);
		for (n = 0; n < 40 && !dn; n++) begin
			@(negedge clk_sys);
			cmd_valid = 0;
			if (n == sa + 1) pb = req_pins_n_out;
			if (address_strobe_n_out === 1'b0) begin
				pa = req_pins_n_out;
				sa = n;
			end
			if (done === 1'b1) begin
				dn = 1;
				chk("done_fault", 33'(f), 33'(done_fault));
				chk("done_dist", 33'(8), 33'(n - sa));
			end
		end
		chk("done", 1, 33'(dn));
		chk("pins_a", ~a, pa);
		chk("pins_b", eb, pb);
		$display("command test end");
	endtask : run_cmd
	// block long enough to settle, then watch ready through the release glitch window
	task t_block;
		blk = 1;
		repeat (5) @(negedge clk_sys);
		chk("blk_ready", 0, 33'(cmd_ready));
		@(negedge clk_sys) blk = 0;
		@(negedge clk_sys) chk("settle1", 0, 33'(cmd_ready));
		@(negedge clk_sys) chk("settle2", 0, 33'(cmd_ready));
		run_cmd(33'h0_0000_0040, 8'h01, 8'hFF, 2'h0, 0, 0);
	endtask : t_block
	task t_init;
		logic dn;
		dn = 0;
		offer(33'h0_0000_1000, 0);
		@(negedge clk_sys) cmd_valid = 0;
		ini = 1;
		repeat (6) begin
			@(negedge clk_sys);
			if (done === 1'b1) dn = 1;
		end
		chk("abort_done", 0, 33'(dn));
		chk("init_seen", 1, 33'(bus_init_seen));
		chk("abort_busy", 0, {busy, cmd_ready, address_strobe_n_oe});
		ini = 0;
		repeat (4) @(negedge clk_sys);
		$display("init test end");
	endtask : t_init
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		run_cmd(33'h1_2345_6788, 8'hA5, 8'h0F, 2'h2, 0, 0);
		gdly = 4'h5;
		run_cmd(33'h0_FEDC_BA98, 8'h5A, 8'hF0, 2'h1, 1, 0);
		gdly = 4'h0;
		run_cmd(33'h1_0000_0008, 8'hFF, 8'h01, 2'h3, 0, 1);
		chk("keep_req", 0, 33'(bus_request_n));
		run_cmd(33'h0_0000_0010, 8'h00, 8'h80, 2'h0, 0, 1);
		run_cmd(33'h0_0000_0018, 8'h3C, 8'h3C, 2'h1, 1, 0);
		t_block();
		t_init();
		t_reset();
		run_cmd(33'h1_FFFF_FFF8, 8'h81, 8'h7E, 2'h2, 0, 0);
		end_of_test();
	end
endmodule : lsbs_host_tb
